// file: logic/pbcs_pkg.sv
// Package with register map, field layout and reset values of the base clock selector
package pbcs_pkg;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_LOOP_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_BANDWIDTH = 8'h04;
    localparam logic [7:0] ADDR_MULT = 8'h08;
    localparam logic [7:0] ADDR_LINEAR = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // ****************************************
    // Loop control fields
    // ****************************************
    localparam int LC_IRQ_EN = 7;
    localparam int LC_FLAG = 6;
    localparam int LC_LOOP_EN = 5;
    localparam int LC_SELECT = 4;
    localparam int LC_PWR_HI = 1;
    localparam int LC_PWR_LO = 0;
    // ****************************************
    // Bandwidth control fields
    // ****************************************
    localparam int BW_AUTO = 7;
    localparam int BW_LOCK = 6;
    localparam int BW_ACQ = 5;
    // ****************************************
    // Status fields
    // ****************************************
    localparam int ST_ACTIVE_VCO = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_OSC_RUN = 2;
    localparam int ST_LOOP_RUN = 3;
    // ****************************************
    // Reset values and special codes
    // ****************************************
    localparam logic [11:0] MULT_RESET = 12'h040;
    localparam logic [7:0] LINEAR_RESET = 8'h40;
    localparam logic [1:0] PWR_RESET = 2'h0;
    localparam logic [1:0] PWR_ILLEGAL = 2'h3;
    localparam logic [11:0] MULT_ONE = 12'h001;
    // ****************************************
    // Switch timing
    // ****************************************
    localparam int SYNC_STAGES = 3;
endpackage

// file: logic/pbcs_sync_gate.sv
// Per-domain synchroniser that gates one source clock on and off at a low phase
`timescale 1ns/1ps
module pbcs_sync_gate #(
    parameter int STAGES = pbcs_pkg::SYNC_STAGES
) (
    input wire logic src_clk_in,
    input wire logic rstn_in,
    input wire logic want_in,
    output logic run_out
);
    logic [STAGES-1:0] shift;

    // ****************************************
    // Select synchroniser on falling edge
    // ****************************************
    // per-domain sync
    always_ff @(negedge src_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift <= '0;
        end else begin
            shift <= {shift[STAGES-2:0], want_in};
        end
    end

    assign run_out = shift[STAGES-1];
endmodule

// file: logic/pbcs_clock_switch.sv
// Glitch-free two-source clock switch followed by divide-by-two
`timescale 1ns/1ps
module pbcs_clock_switch (
    input wire logic crystal_clock_in,
    input wire logic vco_clock_in,
    input wire logic rstn_in,
    input wire logic select_vco_in,
    input wire logic osc_gate_in,
    output logic base_clock_out,
    output logic crystal_run_out,
    output logic vco_run_out
);
    logic xtal_run;
    logic vco_run;
    logic gated_clk;
    logic div;

    // Each side waits for the other side to stop first
    pbcs_sync_gate #(.STAGES(pbcs_pkg::SYNC_STAGES)) u_xtal (
        .src_clk_in(crystal_clock_in),
        .rstn_in(rstn_in),
        .want_in(!select_vco_in && !vco_run),
        .run_out(xtal_run)
    );

    pbcs_sync_gate #(.STAGES(pbcs_pkg::SYNC_STAGES)) u_vco (
        .src_clk_in(vco_clock_in),
        .rstn_in(rstn_in),
        .want_in(select_vco_in && !xtal_run),
        .run_out(vco_run)
    );

    // ****************************************
    // Clock mux, held low during handover
    // ****************************************
    // output static meanwhile
    assign gated_clk = ((crystal_clock_in && xtal_run) || (vco_clock_in && vco_run)) && osc_gate_in;

    // ****************************************
    // Divide by two for 50 percent duty
    // ****************************************
    // divide by two
    always_ff @(posedge gated_clk or negedge rstn_in) begin
        if (!rstn_in) begin
            div <= 1'b0;
        end else begin
            div <= !div;
        end
    end

    assign base_clock_out = div;
    assign crystal_run_out = xtal_run;
    assign vco_run_out = vco_run;
endmodule

// file: logic/pbcs_base_clock_selector.sv
// Loop control registers, APB slave and base clock source selection
//
// Function
// - Multiplier zero behaves exactly like multiplier one (the multiplier output gives one; the register reads back zero).
// - Linear range zero disables loop and forces crystal as base clock.
// - Source change waits up to three cycles of each clock, output static.
// - Selected clock divided by two, 50 percent duty.
// - Select bit cannot be set while loop enable is clear.
// - While select is set, loop enable is forced one and read-only.
// - Loop off or linear range zero holds select cleared, read-only.
// - Loop enabled blocks writes to power range and programming registers.
// - Manual bandwidth: irq enable ignores writes, reads zero; reset clears.
// - Lock toggle sets flag; irq output is flag and enable.
// - Manual bandwidth: flag and lock indicator read zero.
// - Reading loop control clears flag; reset clears it too.
// - Reset sets loop enable, clears select and power range.
// - Power range 00,01,10 give multipliers 1,2,4; never program 11.
// - Run-in-stop bit keeps oscillator running in stop mode; else follows osc enable.
// - Loop runs only while osc enable input asserted; oscillator also runs in stop mode with run-in-stop set.
// - Auto mode: lock indicator read-only, set while VCO at frequency.
// - Auto bandwidth bit read/write, one automatic, reset clears.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module pbcs_base_clock_selector (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic crystal_clock_in,
    input wire logic vco_clock_in,
    input wire logic vco_locked_in,
    input wire logic vco_acq_in,
    input wire logic osc_enable_in,
    input wire logic stop_mode_in,
    input wire logic osc_run_in_stop,
    output logic base_clock_out,
    output logic lock_irq_out,
    output logic osc_run_out,
    output logic loop_run_out,
    output logic [11:0] feedback_mult_out,
    output logic [7:0] vco_linear_range_out,
    output logic [1:0] vco_power_range_out,
    output logic tracking_out
);
    // ****************************************
    // Register state
    // ****************************************
    logic lock_irq_enable;
    logic lock_change_flag;
    logic loop_enable;
    logic base_source_select;
    logic [1:0] vco_power_range;
    logic auto_bw;
    logic acq_manual;
    logic [11:0] feedback_mult;
    logic [7:0] vco_linear_range;
    logic lock_s1;
    logic lock_s2;
    logic lock_prev;
    logic acq_s1;
    logic acq_s2;
    logic osc_s1;
    logic osc_s2;
    logic stop_s1;
    logic stop_s2;
    logic xtal_run_s1;
    logic xtal_run_s2;
    logic vco_run_s1;
    logic vco_run_s2;
    logic crystal_run;
    logic vco_run;
    logic access;
    logic wr;
    logic rd;
    logic linear_zero;
    logic loop_active;
    logic osc_gate;
    logic lock_view;
    logic [7:0] loop_control_reg;
    logic [7:0] bandwidth_control_reg;
    logic [7:0] next_loop_control;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    assign access = psel_in && penable_in;
    assign wr = access && pwrite_in;
    assign rd = access && !pwrite_in;
    assign pready_out = 1'b1;
    assign linear_zero = (vco_linear_range == 8'h00);
    assign next_loop_control = pwdata_in[7:0];

    // ****************************************
    // Input synchronisers
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            acq_s1 <= 1'b0;
            acq_s2 <= 1'b0;
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            stop_s1 <= 1'b0;
            stop_s2 <= 1'b0;
            xtal_run_s1 <= 1'b0;
            xtal_run_s2 <= 1'b0;
            vco_run_s1 <= 1'b0;
            vco_run_s2 <= 1'b0;
        end else begin
            lock_s1 <= vco_locked_in;
            lock_s2 <= lock_s1;
            acq_s1 <= vco_acq_in;
            acq_s2 <= acq_s1;
            osc_s1 <= osc_enable_in;
            osc_s2 <= osc_s1;
            stop_s1 <= stop_mode_in;
            stop_s2 <= stop_s1;
            xtal_run_s1 <= crystal_run;
            xtal_run_s2 <= xtal_run_s1;
            vco_run_s1 <= vco_run;
            vco_run_s2 <= vco_run_s1;
        end
    end

    // ****************************************
    // Lock indicator and change flag
    // ****************************************
    // lock follows VCO in auto
    assign lock_view = auto_bw && lock_s2;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= lock_view;
        end
    end

    // toggle sets flag, set beats read clear
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_change_flag <= 1'b0;
        end else if (!auto_bw) begin
            lock_change_flag <= 1'b0;
        end else if (lock_view != lock_prev) begin
            lock_change_flag <= 1'b1;
        end else if (rd && hit(paddr_in, pbcs_pkg::ADDR_LOOP_CONTROL)) begin
            lock_change_flag <= 1'b0;
        end
    end

    assign lock_irq_out = lock_change_flag && lock_irq_enable;

    // ****************************************
    // Loop control register
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            loop_enable <= 1'b1;
            base_source_select <= 1'b0;
            vco_power_range <= pbcs_pkg::PWR_RESET;
            lock_irq_enable <= 1'b0;
        end else begin
            if (wr && hit(paddr_in, pbcs_pkg::ADDR_LOOP_CONTROL)) begin
                lock_irq_enable <= auto_bw && next_loop_control[pbcs_pkg::LC_IRQ_EN];
                // loop stays on while select set
                loop_enable <= next_loop_control[pbcs_pkg::LC_LOOP_EN] || base_source_select;
                base_source_select <= next_loop_control[pbcs_pkg::LC_SELECT] && loop_enable && !linear_zero;
                // power range locked while loop on
                if (!loop_enable) begin
                    vco_power_range <= next_loop_control[pbcs_pkg::LC_PWR_HI:pbcs_pkg::LC_PWR_LO];
                end
            end else begin
                if (!auto_bw) begin
                    lock_irq_enable <= 1'b0;
                end
                if (!loop_enable || linear_zero) begin
                    base_source_select <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Bandwidth and loop programming registers
    // ****************************************
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            auto_bw <= 1'b0;
            acq_manual <= 1'b0;
            feedback_mult <= pbcs_pkg::MULT_RESET;
            vco_linear_range <= pbcs_pkg::LINEAR_RESET;
        end else if (wr) begin
            if (hit(paddr_in, pbcs_pkg::ADDR_BANDWIDTH)) begin
                auto_bw <= pwdata_in[pbcs_pkg::BW_AUTO];
                if (!auto_bw) begin
                    acq_manual <= pwdata_in[pbcs_pkg::BW_ACQ];
                end
            end
            if (hit(paddr_in, pbcs_pkg::ADDR_MULT) && !loop_enable) begin
                feedback_mult <= pwdata_in[11:0];
            end
            if (hit(paddr_in, pbcs_pkg::ADDR_LINEAR) && !loop_enable) begin
                vco_linear_range <= pwdata_in[7:0];
            end
        end
    end

    // ****************************************
    // Oscillator and loop enables
    // ****************************************
    // run in stop keeps oscillator on
    assign osc_gate = osc_s2 || (osc_run_in_stop && stop_s2);
    // loop needs osc enable; linear zero disables loop
    assign loop_active = loop_enable && osc_s2 && !linear_zero;
    assign osc_run_out = osc_gate;
    assign loop_run_out = loop_active;
    assign feedback_mult_out = (feedback_mult == 12'h000) ? pbcs_pkg::MULT_ONE : feedback_mult;
    assign vco_linear_range_out = vco_linear_range;
    assign vco_power_range_out = vco_power_range;
    assign tracking_out = auto_bw ? acq_s2 : acq_manual;

    // ****************************************
    // Clock switch
    // ****************************************
    // crystal forced when linear zero
    pbcs_clock_switch u_switch (
        .crystal_clock_in(crystal_clock_in),
        .vco_clock_in(vco_clock_in),
        .rstn_in(rstn_in),
        .select_vco_in(base_source_select && !linear_zero),
        .osc_gate_in(osc_gate),
        .base_clock_out(base_clock_out),
        .crystal_run_out(crystal_run),
        .vco_run_out(vco_run)
    );

    // ****************************************
    // Read mux
    // ****************************************
    assign loop_control_reg = {lock_irq_enable, lock_change_flag, loop_enable, base_source_select,
                               2'h0, vco_power_range};
    assign bandwidth_control_reg = {auto_bw, lock_view, (auto_bw ? acq_s2 : acq_manual), 5'h00};

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pslverr_out <= 1'b0;
            if (psel_in && !penable_in) begin
                prdata_out <= 32'h0000_0000;
                unique case (paddr_in)
                    pbcs_pkg::ADDR_LOOP_CONTROL: prdata_out <= {24'h000000, loop_control_reg};
                    pbcs_pkg::ADDR_BANDWIDTH: prdata_out <= {24'h000000, bandwidth_control_reg};
                    pbcs_pkg::ADDR_MULT: prdata_out <= {20'h00000, feedback_mult};
                    pbcs_pkg::ADDR_LINEAR: prdata_out <= {24'h000000, vco_linear_range};
                    pbcs_pkg::ADDR_STATUS: prdata_out <= {28'h0000000, loop_active, osc_gate,
                                                          xtal_run_s2 == vco_run_s2, vco_run_s2};
                    default: pslverr_out <= 1'b1;
                endcase
            end
        end
    end
endmodule

// file: bench/pbcs_props.sv
// Port checker for the base clock selector
`timescale 1ns/1ps
module pbcs_props (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic osc_enable_in,
    input wire logic osc_run_in_stop,
    input wire logic lock_irq_out,
    input wire logic osc_run_out,
    input wire logic loop_run_out,
    input wire logic [11:0] feedback_mult_out,
    input wire logic [7:0] vco_linear_range_out,
    input wire logic [1:0] vco_power_range_out
);
    // ****************************************
    // Bus decode and bandwidth mode shadow
    // ****************************************
    logic auto_sh;
    wire logic acc = psel_in && penable_in && pready_out;
    wire logic wr_acc = acc && pwrite_in;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            auto_sh <= 1'b0;
        end else if (wr_acc && paddr_in == pbcs_pkg::ADDR_BANDWIDTH) begin
            auto_sh <= pwdata_in[pbcs_pkg::BW_AUTO];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_rd_ctl;
        acc && !pwrite_in && paddr_in == pbcs_pkg::ADDR_LOOP_CONTROL;
    endsequence
    sequence s_manual;
        !auto_sh [*3];
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_mult_nonzero: assert property (feedback_mult_out != 12'h000)
        else $error("multiplier output is zero");
    a_linear_zero_off: assert property ((vco_linear_range_out == 8'h00) [*5] |-> !loop_run_out)
        else $error("loop runs with zero linear range");
    a_select_needs_loop: assert property (s_rd_ctl |-> !prdata_out[4] || prdata_out[5])
        else $error("select reads set with loop off");
    a_manual_flags_zero: assert property (s_manual ##0 s_rd_ctl |-> prdata_out[7:6] == 2'b00)
        else $error("flag or irq enable set in manual mode");
    a_manual_no_irq: assert property (s_manual |-> !lock_irq_out)
        else $error("interrupt in manual mode");
    a_prog_by_write: assert property (($changed(feedback_mult_out) || $changed(vco_linear_range_out)
        || $changed(vco_power_range_out)) |-> $past(wr_acc))
        else $error("programming value changed without a write");
    a_osc_gate_off: assert property ((!osc_enable_in && !osc_run_in_stop) [*5] |-> !osc_run_out)
        else $error("oscillator runs without enable");
    a_loop_gate_off: assert property ((!osc_enable_in) [*5] |-> !loop_run_out)
        else $error("loop runs without enable");
    a_osc_keep_run: assert property ((osc_enable_in && osc_run_in_stop) [*5] |-> osc_run_out)
        else $error("oscillator stopped while enabled");
endmodule

bind pbcs_base_clock_selector pbcs_props pbcs_props_i (.clk_in, .rstn_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .osc_enable_in, .osc_run_in_stop,
    .lock_irq_out, .osc_run_out, .loop_run_out, .feedback_mult_out, .vco_linear_range_out,
    .vco_power_range_out);

// file: bench/pbcs_sim_model.sv
// System integration side model: oscillator enable and base clock timing
`timescale 1ns/1ps
module pbcs_sim_model (
    input wire logic base_clock_in,
    input wire logic stop_req_in,
    output logic osc_enable_out,
    output logic stop_mode_out,
    output real high_ns_out,
    output real min_ns_out,
    output int edges_out
);
    // ****************************************
    // Enables and pulse width monitor
    // ****************************************
    real t_rise = 0.0;
    real t_fall = 0.0;
    assign osc_enable_out = !stop_req_in;
    assign stop_mode_out = stop_req_in;
    initial begin
        high_ns_out = 0.0;
        min_ns_out = 1.0e9;
        edges_out = 0;
    end
    always @(posedge base_clock_in) begin
        if (t_fall > 0.0 && $realtime - t_fall < min_ns_out) begin
            min_ns_out = $realtime - t_fall;
        end
        t_rise = $realtime;
        edges_out++;
    end
    always @(negedge base_clock_in) begin
        if (t_rise > 0.0) begin
            high_ns_out = $realtime - t_rise;
            if (high_ns_out < min_ns_out) begin
                min_ns_out = high_ns_out;
            end
            t_fall = $realtime;
        end
    end
endmodule

// file: bench/test_pll_base_clock_selector.sv
// Self-checking bench for the base clock selector
`timescale 1ns/1ps
module test_pll_base_clock_selector;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} pbcs_exp_t;
    logic clk_in, rstn_in, psel, penable, pwrite, xclk, vclk, locked, stop_req, run_stop;
    logic [7:0] paddr;
    logic [31:0] pwdata, rnd;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, base_clk, irq, osc_run, loop_run, osc_en, stop_mode;
    wire logic [11:0] mult;
    wire logic [7:0] lin;
    wire logic [1:0] pwr;
    wire logic trk;
    real high_ns, min_ns;
    int edges, n0;
    int failures = 0;
    int total_checks = 0;
    int seed = 32'h8116;
    pbcs_exp_t exp_q[$];
    pbcs_exp_t ex;
    pbcs_base_clock_selector pbcs_base_clock_selector_i (.clk_in, .rstn_in, .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .crystal_clock_in(xclk),
        .vco_clock_in(vclk), .vco_locked_in(locked), .vco_acq_in(1'b0), .osc_enable_in(osc_en),
        .stop_mode_in(stop_mode), .osc_run_in_stop(run_stop), .base_clock_out(base_clk),
        .lock_irq_out(irq), .osc_run_out(osc_run), .loop_run_out(loop_run), .feedback_mult_out(mult),
        .vco_linear_range_out(lin), .vco_power_range_out(pwr), .tracking_out(trk));
    pbcs_sim_model pbcs_sim_model_i (.base_clock_in(base_clk), .stop_req_in(stop_req),
        .osc_enable_out(osc_en), .stop_mode_out(stop_mode), .high_ns_out(high_ns),
        .min_ns_out(min_ns), .edges_out(edges));
    // ****************************************
    // Clocks, compares and bus tasks
    // ****************************************
    initial begin clk_in = 0; forever #10 clk_in = ~clk_in; end
    initial begin xclk = 0; forever #20 xclk = ~xclk; end
    initial begin vclk = 0; forever #13 vclk = ~vclk; end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_ns(input real got, input real exp);
        total_checks++;
        if (got < exp - 0.5 || got > exp + 0.5) begin
            failures++;
            $display("mismatch at %0t: width %0f expected %0f", $time, got, exp);
        end
    endtask
    task automatic wc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
        exp_q.push_back('{d, m, e});
        apb(1'b0, a, 32'h0);
    endtask
    always @(posedge clk_in) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            ex = exp_q.pop_front();
            chk(prdata & ex.m, ex.d & ex.m);
            chk({31'h0, pslverr}, {31'h0, ex.e});
        end
    end
    task automatic test_done;
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        test_done;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, locked, stop_req, run_stop, rstn_in} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wc(16);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        rd(8'h00, 32'h20, 32'hff, 1'b0);
        rd(8'h14, 32'h0, 32'hffffffff, 1'b1);
        wc(100);
        chk_ns(high_ns, 40.0);
        apb(1'b1, 8'h08, $random(seed));
        rd(8'h08, 32'h40, 32'hfff, 1'b0);
        apb(1'b1, 8'h00, 32'h22);
        rd(8'h00, 32'h20, 32'hff, 1'b0);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h00, 32'h10);
        rd(8'h00, 32'h00, 32'hff, 1'b0);
        for (int e = 0; e < 3; e++) begin
            apb(1'b1, 8'h00, 32'(e));
            rd(8'h00, 32'(e), 32'hff, 1'b0);
            chk({30'h0, pwr}, 32'(e));
        end
        rnd = $random(seed) | 32'h2;
        apb(1'b1, 8'h08, {20'h0, rnd[11:0]});
        chk({20'h0, mult}, {20'h0, rnd[11:0]});
        apb(1'b1, 8'h08, 32'h0);
        chk({20'h0, mult}, 32'h1);
        apb(1'b1, 8'h0c, 32'h0);
        chk({24'h0, lin}, 32'h0);
        apb(1'b1, 8'h00, 32'h20);
        apb(1'b1, 8'h00, 32'h30);
        rd(8'h00, 32'h00, 32'h10, 1'b0);
        wc(10);
        chk({31'h0, loop_run}, 32'h0);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h0c, 32'h40);
        apb(1'b1, 8'h08, 32'h40);
        apb(1'b1, 8'h00, 32'h20);
        apb(1'b1, 8'h00, 32'h30);
        rd(8'h00, 32'h30, 32'h30, 1'b0);
        wc(100);
        chk_ns(high_ns, 26.0);
        chk_ns(min_ns, 26.0);
        apb(1'b1, 8'h00, 32'h00);
        rd(8'h00, 32'h20, 32'h30, 1'b0);
        wc(100);
        chk_ns(high_ns, 40.0);
        chk_ns(min_ns, 26.0);
        apb(1'b1, 8'h00, 32'ha0);
        rd(8'h00, 32'h20, 32'he0, 1'b0);
        apb(1'b1, 8'h04, 32'h80);
        rd(8'h04, 32'h80, 32'h80, 1'b0);
        apb(1'b1, 8'h00, 32'ha0);
        locked <= 1'b1;
        wc(10);
        chk({31'h0, irq}, 32'h1);
        rd(8'h00, 32'he0, 32'he0, 1'b0);
        rd(8'h00, 32'ha0, 32'he0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        rd(8'h04, 32'hc0, 32'hc0, 1'b0);
        apb(1'b1, 8'h04, 32'h00);
        locked <= 1'b0;
        wc(10);
        rd(8'h00, 32'h20, 32'he0, 1'b0);
        rd(8'h04, 32'h00, 32'hc0, 1'b0);
        apb(1'b1, 8'h04, 32'h20);
        chk({31'h0, trk}, 32'h1);
        rd(8'h04, 32'h20, 32'he0, 1'b0);
        stop_req <= 1'b1;
        wc(20);
        chk({30'h0, osc_run, loop_run}, 32'h0);
        n0 = edges;
        wc(20);
        chk(32'(edges), 32'(n0));
        run_stop <= 1'b1;
        wc(10);
        chk({31'h0, osc_run}, 32'h1);
        stop_req <= 1'b0;
        wc(10);
        chk({30'h0, osc_run, loop_run}, 32'h3);
        test_done;
    end
endmodule
